/* File: dv/magnetometer_command_engine_tb.sv */
// Self-checking bench of the magnetometer command engine.
// Host model on the link; conversion chain and register master are here.
`timescale 1ns/1ns
`default_nettype none
module magnetometer_command_engine_tb
   import mag_cmd_pkg::*;
;
   logic sys_clk_i, rst_i, lclk, lsel_n, mosi, miso, miso_oe_n, rdy, cstart;
   logic ext_start, nv_fix, reg_wr, reg_rd;
   logic cdone = 1'b0;
   logic [3:0] caxes, reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [79:0] rx;
   result_t cres;
   int num_errors, n_checks, conv_lat;
   int cnt = 0;

   spi_host_model u_spi_host_model (.link_clk_o(lclk), .link_sel_n_o(lsel_n),
      .link_mosi_o(mosi), .link_miso_i(miso));

   magnetometer_command_engine #(.GAP_CYCLES(4)) u_magnetometer_command_engine (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(lclk), .link_sel_n_i(lsel_n),
      .link_mosi_i(mosi), .link_miso_o(miso), .link_miso_oe_n_o(miso_oe_n),
      .ext_start_pin_i(ext_start), .data_ready_flag_o(rdy), .conv_start_o(cstart),
      .conv_axes_o(caxes), .conv_done_i(cdone), .conv_result_i(cres),
      .nv_fix_i(nv_fix), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   // Conversion chain answers conv_lat cycles after a start
   always @(posedge sys_clk_i) begin
      cdone <= (cnt == 1);
      if (cstart === 1'b1) cnt <= conv_lat;
      else if (cnt > 0) cnt <= cnt - 1;
   end

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected value at %0t: %h not %h", $time, got, exp);
      end
   endtask

   task automatic chk_status(input logic [7:0] got, input logic [7:0] exp);
      chk_val({8'h00, got}, {8'h00, exp});
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk_i);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk_i);
      reg_rd <= 1'b0;
      @(negedge sys_clk_i);
      d = reg_rdata;
   endtask

   task automatic send(input logic [31:0] c, input int nc, input int nr,
                       input logic [7:0] st);
      logic [79:0] t;
      u_spi_host_model.frame(c, nc, nr, rx);
      t = rx >> (8 * (nr - 1));
      chk_status(t[7:0], st);
   endtask

   task automatic wait_sig(input bit strt);
      int k;
      k = 0;
      while ((strt ? cstart : rdy) !== 1'b1 && k < 2000) begin
         @(negedge sys_clk_i);
         k++;
      end
      if (k == 2000) begin
         num_errors++;
         $display("unexpected hang at %0t", $time);
      end
   endtask

   task automatic s_words();
      send(32'h60ABCD28, 4, 1, 8'h00);
      send(32'h50280000, 2, 3, 8'h00);
      chk_val(rx[15:0], 16'hABCD);
      send(32'hE0000000, 1, 1, 8'h00);
      send(32'h60111128, 4, 1, 8'h00);
      send(32'hD0000000, 1, 1, 8'h00);
      send(32'h50280000, 2, 3, 8'h00);
      chk_val(rx[15:0], 16'hABCD);
      send(32'h60111184, 4, 1, 8'h00);
      send(32'h50840000, 2, 3, 8'h00);
      chk_val(rx[15:0], 16'h5555);
      send(32'h60222228, 4, 1, 8'h00);
      send(32'hF0000000, 1, 1, 8'h04);
      send(32'h50280000, 2, 3, 8'h00);
      chk_val(rx[15:0], 16'hABCD);
   endtask

   task automatic s_single();
      logic [31:0] d;
      conv_lat = 400;
      send(32'h30000000, 1, 1, 8'h20);
      chk_val({12'h000, caxes}, 16'h0003);
      send(32'h80000000, 1, 1, 8'h30);
      send(32'h43000000, 1, 1, 8'h30);
      wait_sig(1'b0);
      reg_read(REG_STATE, d);
      chk_val({15'h0000, d[8]}, 16'h0001);
      reg_read(4'hC, d);
      chk_val(d[15:0], 16'h0000);
      send(32'h43000000, 1, 5, 8'h01);
      chk_val(rx[31:16], 16'h1111);
      chk_val(rx[15:0], 16'h2222);
      send(32'h43000000, 1, 1, 8'h10);
   endtask

   task automatic s_burst();
      conv_lat = 10;
      send(32'h1F000000, 1, 1, 8'h80);
      chk_val({12'h000, caxes}, 16'h000F);
      send(32'h31000000, 1, 1, 8'h90);
      wait_sig(1'b0);
      wait_sig(1'b1);
      @(negedge sys_clk_i);
      chk_val({15'h0000, rdy}, 16'h0000);
      send(32'h80000000, 1, 1, 8'h00);
      send(32'h60001024, 4, 1, 8'h00);
      send(32'h21000000, 1, 1, 8'h40);
      send(32'h11000000, 1, 1, 8'h50);
      chk_val({15'h0000, rdy}, 16'h0000);
      // Temperature moves by exactly the limit now written to word 9
      @(posedge sys_clk_i);
      cres.t <= 16'h1121;
      wait_sig(1'b0);
      chk_val({15'h0000, rdy}, 16'h0001);
      send(32'h80000000, 1, 1, 8'h00);
      chk_val({15'h0000, miso_oe_n}, 16'h0001);
   endtask

   task automatic s_flags();
      @(posedge sys_clk_i);
      nv_fix <= 1'b1;
      @(posedge sys_clk_i);
      nv_fix <= 1'b0;
      send(32'h00000000, 1, 1, 8'h08);
      send(32'h00000000, 1, 1, 8'h00);
      conv_lat = 400;
      @(posedge sys_clk_i);
      ext_start <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      ext_start <= 1'b0;
      send(32'h00000000, 1, 1, 8'h20);
      wait_sig(1'b0);
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #3000000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      rst_i = 1'b1;
      {ext_start, nv_fix, reg_wr, reg_rd} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h00000000;
      conv_lat = 10;
      cres = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      for (int a = 0; a < 34; a++) begin
         reg_write(REG_FACT_ADDR, a);
         reg_write(REG_FACT_DATA, (a == 1) ? 32'h0003 : (a == 33) ? 32'h5555 : 32'hFFFF);
      end
      s_words();
      s_single();
      s_burst();
      s_flags();
      report_and_stop();
   end
endmodule
`default_nettype wire

/* File: dv/spi_host_model.sv */
// Host-side serial master model: mode 3, msb first, one command per frame.
// The bench calls its frame task; link clock stands high outside frames.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   // Link pins
   output logic link_clk_o,
   output logic link_sel_n_o,
   output logic link_mosi_o,
   input wire logic link_miso_i
);
   initial begin
      link_clk_o = 1'b1;
      link_sel_n_o = 1'b1;
      link_mosi_o = 1'b0;
   end

   // command bytes msb first, then answer bytes
   task automatic frame(input logic [31:0] cmd, input int nc, input int nr,
                        output logic [79:0] rx);
      rx = '0;
      link_sel_n_o = 1'b0;
      #160;
      for (int i = 0; i < 8 * (nc + nr); i++) begin
         link_clk_o = 1'b0;
         link_mosi_o = (i < 8 * nc) ? cmd[31 - i] : 1'b0;
         #160;
         if (i >= 8 * nc) begin
            rx = {rx[78:0], link_miso_i};
         end
         link_clk_o = 1'b1;
         #160;
      end
      link_sel_n_o = 1'b1;
      // Released line shows the inverse of its last bit
      link_mosi_o = ~link_mosi_o;
      #640;
   endtask
endmodule
`default_nettype wire

/* File: logic/mag_cmd_pkg.sv */
// Constants and types of the magnetometer command engine.
// Shared by the engine and by whoever drives its link and conversion ports.
package mag_cmd_pkg;

   // Opcodes, upper nibble of the first command byte
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_BURST = 4'h1;
   localparam logic [3:0] OP_WATCH = 4'h2;
   localparam logic [3:0] OP_SINGLE = 4'h3;
   localparam logic [3:0] OP_FETCH = 4'h4;
   localparam logic [3:0] OP_WFETCH = 4'h5;
   localparam logic [3:0] OP_WSTORE = 4'h6;
   localparam logic [3:0] OP_LEAVE = 4'h8;
   localparam logic [3:0] OP_RECALL = 4'hD;
   localparam logic [3:0] OP_SAVE = 4'hE;
   localparam logic [3:0] OP_REBOOT = 4'hF;

   // Command lengths in bytes
   localparam logic [2:0] LEN_ONE = 3'h1;
   localparam logic [2:0] LEN_WFETCH = 3'h2;
   localparam logic [2:0] LEN_WSTORE = 3'h4;

   // Axis select bits, ordered Z Y X T from msb to lsb
   localparam int unsigned AX_T = 0;
   localparam int unsigned AX_X = 1;
   localparam int unsigned AX_Y = 2;
   localparam int unsigned AX_Z = 3;
   localparam logic [3:0] AXES_NONE = 4'h0;

   // Word memory
   localparam int unsigned WORD_CNT = 64;
   localparam logic [5:0] FACTORY_BASE = 6'h20;
   localparam logic [5:0] W_CFG = 6'h01;
   localparam logic [5:0] W_XY_LIM = 6'h07;
   localparam logic [5:0] W_Z_LIM = 6'h08;
   localparam logic [5:0] W_T_LIM = 6'h09;
   localparam int unsigned CFG_REL_BIT = 12;

   // Response data bytes after the status byte
   localparam int unsigned RESP_MAX = 8;

   // Software register port offsets
   localparam logic [3:0] REG_FACT_ADDR = 4'h0;
   localparam logic [3:0] REG_FACT_DATA = 4'h4;
   localparam logic [3:0] REG_STATE = 4'h8;

   // Reset values
   localparam logic [1:0] SYNC_HIGH = 2'h3;
   localparam logic [1:0] SYNC_LOW = 2'h0;

   typedef enum logic [3:0] {
      MODE_IDLE = 4'b0001,
      MODE_BURST = 4'b0010,
      MODE_WATCH = 4'b0100,
      MODE_SINGLE = 4'b1000
   } mode_t;

   typedef struct packed {
      logic burst;
      logic watch;
      logic polling;
      logic error;
      logic corrected;
      logic reset_done;
      logic [1:0] follow;
   } status_t;

   // Field order puts T at the low 16 bits, Z at the top
   typedef struct packed {
      logic [15:0] z;
      logic [15:0] y;
      logic [15:0] x;
      logic [15:0] t;
   } result_t;

endpackage

/* File: logic/magnetometer_command_engine.sv */
// Command interpreter and mode controller of a three-axis magnetic sensor.
// Assumes a mode-3 serial master on the link pins (slower than sys_clk_i / 6),
// a conversion chain on sys_clk_i, and a software port on sys_clk_i.
//
// Overview of operation
// R1: every command answers a status byte: modes, error, corrected, reset, follow count
// R2: after measurement or word reads, low status bits encode following data bytes
// R3: error when reading a measurement not yet done or already read
// R4: corrected flag set whenever nonvolatile memory corrected a single bit
// R5: single command or external start pulse enters polling with flag set
// R6: leave opcode ends burst or change-watch and returns to idle
// R7: leave during polling is rejected; status shows error and polling flag
// R8: soft reboot reinitialises, enters idle, reports reset-done in status
// R9: save copies the whole volatile memory into nonvolatile memory
// R10: recall copies nonvolatile into volatile memory, also automatically at start-up
// R11: word read is opcode then address shifted by two; answer status plus two bytes
// R12: word write is opcode, data high, data low, address; full word written
// R13: words 32 to 63 are factory area, readable but not writable by commands
// R14: words 0 to 9 steer operation; words 10 to 31 are free storage
// R15: upper nibble selects command, lower nibble selects z, y, x, temperature
// R16: each set axis bit is converted; cleared bits are skipped
// R17: all-zero axis bits on burst, single, watch use the stored default mask
// R18: burst accepted only without watch or polling, else error; sets burst flag
// R19: single accepted only without watch or burst, else error; sets polling flag
// R20: data-ready rises when a measurement completes, falls when the next starts
// R21: results follow status high byte first: temperature, X, Y, Z, unselected skipped
// R22: watch start shows in status; data-ready rises when wake limits are crossed
// R23: relative compare zero compares to first measurement, one to previous one
// R24: default axis mask ordered Z, Y, X, temperature from msb down
`timescale 1ns/1ns
`default_nettype none

module magnetometer_command_engine
   import mag_cmd_pkg::*;
#(
   parameter int unsigned GAP_CYCLES = 64
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Serial command link
   input wire logic link_clk_i,
   input wire logic link_sel_n_i,
   input wire logic link_mosi_i,
   output logic link_miso_o,
   output logic link_miso_oe_n_o,
   // Pins
   input wire logic ext_start_pin_i,
   output logic data_ready_flag_o,
   // Conversion chain
   output logic conv_start_o,
   output logic [3:0] conv_axes_o,
   input wire logic conv_done_i,
   input wire result_t conv_result_i,
   // Nonvolatile memory event
   input wire logic nv_fix_i,
   // Software register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o
);

   function automatic logic [2:0] cmd_len(input logic [3:0] op);
      cmd_len = (op == OP_WSTORE) ? LEN_WSTORE : (op == OP_WFETCH) ? LEN_WFETCH : LEN_ONE;
   endfunction

   function automatic logic over(input logic [15:0] a, input logic [15:0] b,
                                 input logic [15:0] lim);
      over = ((a > b) ? (a - b) : (b - a)) >= lim;
   endfunction

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // Synchronisers and edge detection
   logic [1:0] lclk_s_q, sel_s_q, mosi_s_q, pin_s_q;
   logic lclk_d_q, pin_d_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lclk_s_q <= SYNC_HIGH;
         sel_s_q <= SYNC_HIGH;
         mosi_s_q <= SYNC_LOW;
         pin_s_q <= SYNC_LOW;
         lclk_d_q <= 1'b1;
         pin_d_q <= 1'b0;
      end else begin
         lclk_s_q <= {lclk_s_q[0], link_clk_i};
         sel_s_q <= {sel_s_q[0], link_sel_n_i};
         mosi_s_q <= {mosi_s_q[0], link_mosi_i};
         pin_s_q <= {pin_s_q[0], ext_start_pin_i};
         lclk_d_q <= lclk_s_q[1];
         pin_d_q <= pin_s_q[1];
      end
   end

   // Link framing
   logic [2:0] bit_cnt_q, cmd_cnt_q;
   logic [7:0] rx_q, tx_q;
   logic [7:0] cmd_q [4];
   logic resp_phase_q, exec_q;
   logic [7:0] resp_q [RESP_MAX];
   logic [7:0] resp_d [RESP_MAX];
   logic [3:0] resp_idx_q;
   status_t status_w;

   wire link_act = ~sel_s_q[1];
   wire bit_tick = link_act & lclk_s_q[1] & ~lclk_d_q;
   wire byte_done = bit_tick & (bit_cnt_q == 3'h7);
   wire [7:0] rx_byte = {rx_q[6:0], mosi_s_q[1]};
   wire [7:0] first_byte = (cmd_cnt_q == 3'h0) ? rx_byte : cmd_q[0];
   wire cmd_last = (cmd_len(first_byte[7:4]) == 3'(cmd_cnt_q + 3'h1));
   wire [7:0] next_tx = (resp_phase_q && !resp_idx_q[3]) ? resp_q[resp_idx_q[2:0]] : 8'h00;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bit_cnt_q <= 3'h0;
         cmd_cnt_q <= 3'h0;
         rx_q <= 8'h00;
         resp_phase_q <= 1'b0;
         exec_q <= 1'b0;
         for (int i = 0; i < 4; i++) cmd_q[i] <= 8'h00;
      end else begin
         exec_q <= byte_done & ~resp_phase_q & cmd_last;
         if (!link_act) begin
            bit_cnt_q <= 3'h0;
            cmd_cnt_q <= 3'h0;
            resp_phase_q <= 1'b0;
         end else if (bit_tick) begin
            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            rx_q <= rx_byte;
            if (byte_done && !resp_phase_q) begin
               cmd_q[cmd_cnt_q[1:0]] <= rx_byte;
               cmd_cnt_q <= 3'(cmd_cnt_q + 3'h1);
               resp_phase_q <= cmd_last;
            end
         end
      end
   end

   // Answer shifter: status first, then data bytes
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_q <= 8'h00;
         resp_idx_q <= 4'h0;
         for (int i = 0; i < RESP_MAX; i++) resp_q[i] <= 8'h00;
      end else if (exec_q) begin
         // R1: status byte out
         tx_q <= status_w;
         resp_idx_q <= 4'h0;
         for (int i = 0; i < RESP_MAX; i++) resp_q[i] <= resp_d[i];
      end else if (bit_tick) begin
         if (bit_cnt_q == 3'h7) begin
            tx_q <= next_tx;
            resp_idx_q <= resp_idx_q[3] ? resp_idx_q : 4'(resp_idx_q + 4'h1);
         end else begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   assign link_miso_o = tx_q[7];
   assign link_miso_oe_n_o = sel_s_q[1];

   // Word memories
   logic [15:0] vol_q [WORD_CNT];
   logic [15:0] nv_q [WORD_CNT];
   logic boot_q;
   logic [5:0] fact_addr_q;

   // R15: opcode and axis fields
   wire [3:0] op_w = cmd_q[0][7:4];
   wire [3:0] sel_w = cmd_q[0][3:0];
   // R11: address rides above two zero bits
   wire [5:0] rd_addr = cmd_q[1][7:2];
   // R12: address is the fourth byte
   wire [5:0] wr_addr = cmd_q[3][7:2];
   wire [15:0] wr_word = {cmd_q[1], cmd_q[2]};
   // R14: operating words steer the engine
   wire [15:0] cfg_w = vol_q[W_CFG];
   // R24: default mask bits Z Y X T
   wire [3:0] dflt_mask = cfg_w[3:0];
   wire rel_sel = cfg_w[CFG_REL_BIT];
   // R17: default mask on empty selection
   wire [3:0] eff_mask = (sel_w == AXES_NONE) ? dflt_mask : sel_w;

   wire exec_op = exec_q;
   // R13: factory area write-protected
   wire host_we = exec_op && (op_w == OP_WSTORE) && (wr_addr < FACTORY_BASE);
   // R10: recall on command, reboot and start-up
   wire recall_w = boot_q | (exec_op && (op_w == OP_RECALL || op_w == OP_REBOOT));
   // R9: save whole memory
   wire save_w = exec_op && (op_w == OP_SAVE);
   wire fact_we = reg_wr_i && (reg_addr_i == REG_FACT_DATA);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         boot_q <= 1'b1;
         for (int i = 0; i < WORD_CNT; i++) vol_q[i] <= 16'h0000;
      end else begin
         boot_q <= 1'b0;
         if (recall_w) vol_q <= nv_q;
         else if (host_we) vol_q[wr_addr] <= wr_word;
         else if (fact_we) vol_q[fact_addr_q] <= reg_wdata_i[15:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (save_w) nv_q <= vol_q;
      else if (fact_we) nv_q[fact_addr_q] <= reg_wdata_i[15:0];
   end

   // Mode control and measurement
   mode_t mode_q, mode_d;
   logic [3:0] axes_q, axes_d;
   logic start_w, err_d, busy_q, fresh_q, ready_q, first_q, pend_q, corr_q, conv_start_q;
   logic [3:0] conv_axes_q;
   logic [15:0] gap_cnt_q;
   logic [1:0] follow_d;
   result_t res_q, ref_q;

   wire is_idle = (mode_q == MODE_IDLE);
   wire is_burst = (mode_q == MODE_BURST);
   wire is_watch = (mode_q == MODE_WATCH);
   wire is_poll = (mode_q == MODE_SINGLE);
   wire gap_fire = pend_q && (gap_cnt_q == 16'h0000);
   wire reboot_w = exec_op && (op_w == OP_REBOOT);
   wire fetch_ok = exec_op && (op_w == OP_FETCH) && fresh_q;
   wire pin_edge = pin_s_q[1] & ~pin_d_q;

   always_comb begin
      mode_d = mode_q;
      axes_d = axes_q;
      start_w = 1'b0;
      err_d = 1'b0;
      if (conv_done_i && is_poll) mode_d = MODE_IDLE;
      // R5: external start pulse
      if (pin_edge && is_idle) begin
         mode_d = MODE_SINGLE;
         axes_d = dflt_mask;
         start_w = 1'b1;
      end
      if (gap_fire && (is_burst || is_watch)) start_w = 1'b1;
      if (exec_op) begin
         unique case (op_w)
            OP_BURST: begin
               // R18: burst acceptance
               err_d = is_watch | is_poll;
               if (!err_d) begin
                  mode_d = MODE_BURST;
                  axes_d = eff_mask;
                  start_w = 1'b1;
               end
            end
            OP_WATCH: begin
               // R22: enter change-watch
               err_d = is_burst | is_poll;
               if (!err_d) begin
                  mode_d = MODE_WATCH;
                  axes_d = eff_mask;
                  start_w = 1'b1;
               end
            end
            OP_SINGLE: begin
               // R19: single acceptance
               err_d = is_watch | is_burst;
               if (!err_d) begin
                  mode_d = MODE_SINGLE;
                  axes_d = eff_mask;
                  start_w = 1'b1;
               end
            end
            OP_LEAVE: begin
               // R6 R7: leave unless polling
               err_d = is_poll;
               if (!is_poll) begin
                  mode_d = MODE_IDLE;
                  start_w = 1'b0;
               end
            end
            OP_REBOOT: begin
               // R8: reinitialise to idle
               mode_d = MODE_IDLE;
               start_w = 1'b0;
            end
            // R3: stale or missing result
            OP_FETCH: err_d = ~fresh_q;
            OP_NOP, OP_WFETCH, OP_WSTORE, OP_RECALL, OP_SAVE: err_d = 1'b0;
            default: err_d = 1'b1;
         endcase
      end
   end

   // R21: result bytes in order T X Y Z, high byte first
   always_comb begin
      int n;
      n = 0;
      follow_d = 2'h0;
      for (int i = 0; i < RESP_MAX; i++) resp_d[i] = 8'h00;
      if (fetch_ok) begin
         for (int i = 0; i < 4; i++) begin
            if (sel_w[i]) begin
               resp_d[n] = res_q[16*i+8 +: 8];
               resp_d[n+1] = res_q[16*i +: 8];
               n = n + 2;
            end
         end
      end else if (exec_op && op_w == OP_WFETCH) begin
         // R11: two data bytes
         resp_d[0] = vol_q[rd_addr][15:8];
         resp_d[1] = vol_q[rd_addr][7:0];
         n = 2;
      end
      // R2: words following, minus one
      if (n > 0) follow_d = 2'((n / 2) - 1);
   end

   // R1: status fields
   assign status_w = '{burst: (mode_d == MODE_BURST), watch: (mode_d == MODE_WATCH),
                       polling: (mode_d == MODE_SINGLE), error: err_d,
                       corrected: corr_q | nv_fix_i, reset_done: reboot_w, follow: follow_d};

   // R22 R23: wake limit comparison
   wire crossed = (axes_q[AX_T] & over(conv_result_i.t, ref_q.t, vol_q[W_T_LIM]))
                | (axes_q[AX_X] & over(conv_result_i.x, ref_q.x, vol_q[W_XY_LIM]))
                | (axes_q[AX_Y] & over(conv_result_i.y, ref_q.y, vol_q[W_XY_LIM]))
                | (axes_q[AX_Z] & over(conv_result_i.z, ref_q.z, vol_q[W_Z_LIM]));
   wire ready_set = conv_done_i & (~is_watch | (~first_q & crossed));

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= MODE_IDLE;
         axes_q <= AXES_NONE;
         conv_start_q <= 1'b0;
         conv_axes_q <= AXES_NONE;
         busy_q <= 1'b0;
         pend_q <= 1'b0;
         gap_cnt_q <= 16'h0000;
      end else begin
         mode_q <= mode_d;
         axes_q <= axes_d;
         conv_start_q <= start_w;
         // R16: only selected axes converted
         if (start_w) conv_axes_q <= axes_d;
         busy_q <= start_w | (busy_q & ~conv_done_i);
         if (conv_done_i && (is_burst || is_watch)) begin
            pend_q <= 1'b1;
            gap_cnt_q <= 16'(GAP_CYCLES);
         end else if (gap_fire || reboot_w) begin
            pend_q <= 1'b0;
         end else if (pend_q) begin
            gap_cnt_q <= 16'(gap_cnt_q - 16'h0001);
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_q <= 1'b0;
         fresh_q <= 1'b0;
         first_q <= 1'b0;
         corr_q <= 1'b0;
         res_q <= '0;
         ref_q <= '0;
      end else begin
         // R20: set on completion, cleared at next start
         ready_q <= ready_set | (ready_q & ~start_w & ~reboot_w);
         fresh_q <= conv_done_i | (fresh_q & ~fetch_ok & ~reboot_w);
         // R4: sticky until reported
         corr_q <= nv_fix_i | (corr_q & ~exec_op);
         if (conv_done_i) res_q <= conv_result_i;
         // R23: reference follows mode of comparison
         if (conv_done_i && is_watch && (first_q || rel_sel)) ref_q <= conv_result_i;
         if (exec_op && op_w == OP_WATCH && mode_d == MODE_WATCH) first_q <= 1'b1;
         else if (conv_done_i) first_q <= 1'b0;
      end
   end

   assign data_ready_flag_o = ready_q;
   assign conv_start_o = conv_start_q;
   assign conv_axes_o = conv_axes_q;

   // Software register port
   wire [31:0] rd_mux = (reg_addr_i == REG_FACT_ADDR) ? {26'h0, fact_addr_q}
                      : (reg_addr_i == REG_FACT_DATA) ? {16'h0, vol_q[fact_addr_q]}
                      : (reg_addr_i == REG_STATE) ? {21'h0, busy_q, fresh_q, ready_q,
                                                     is_burst, is_watch, is_poll, 1'b0,
                                                     corr_q, 3'h0}
                      : 32'h0;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fact_addr_q <= 6'h00;
         reg_rdata_o <= 32'h0;
      end else begin
         if (reg_wr_i && reg_addr_i == REG_FACT_ADDR) fact_addr_q <= reg_wdata_i[5:0];
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   // Checks
   property p_leave_reject;
      (exec_q && op_w == OP_LEAVE && is_poll) |=> (tx_q[5:4] == 2'b11) && is_poll;
   endproperty
   a_leave_reject: assert property (p_leave_reject) else $error("leave in polling accepted"); // R7

   property p_leave_ok;
      (exec_q && op_w == OP_LEAVE && (is_burst || is_watch)) |=> is_idle && !tx_q[4];
   endproperty
   a_leave_ok: assert property (p_leave_ok) else $error("leave did not return to idle"); // R6

   property p_burst_gate;
      (exec_q && op_w == OP_BURST && (is_watch || is_poll)) |=> tx_q[4] && !tx_q[7] && !is_burst;
   endproperty
   a_burst_gate: assert property (p_burst_gate) else $error("burst accepted in wrong mode"); // R18

   property p_single_go;
      (exec_q && op_w == OP_SINGLE && is_idle) |=> is_poll && tx_q[5] && conv_start_o;
   endproperty
   a_single_go: assert property (p_single_go) else $error("single not started"); // R19

   property p_pin_go;
      (pin_edge && is_idle && !exec_q) |=> is_poll && conv_start_o && (conv_axes_o == dflt_mask);
   endproperty
   a_pin_go: assert property (p_pin_go) else $error("external start ignored"); // R5

   property p_ready_low;
      conv_start_o && !$past(conv_done_i) |-> !data_ready_flag_o;
   endproperty
   a_ready_low: assert property (p_ready_low) else $error("ready high at new start"); // R20

   property p_ready_high;
      (conv_done_i && is_burst) |=> data_ready_flag_o [*2];
   endproperty
   a_ready_high: assert property (p_ready_high) else $error("ready not raised"); // R20

   property p_stale;
      (exec_q && op_w == OP_FETCH && !fresh_q) |=> tx_q[4] && (tx_q[1:0] == 2'b00);
   endproperty
   a_stale: assert property (p_stale) else $error("stale read not flagged"); // R3

   property p_reboot;
      (exec_q && op_w == OP_REBOOT) |=> is_idle && tx_q[2] && !data_ready_flag_o;
   endproperty
   a_reboot: assert property (p_reboot) else $error("reboot status wrong"); // R8

   property p_factory;
      (exec_q && op_w == OP_WSTORE && wr_addr >= FACTORY_BASE) |=> $stable(vol_q[wr_addr]);
   endproperty
   a_factory: assert property (p_factory) else $error("factory word changed"); // R13

   property p_wfetch;
      (exec_q && op_w == OP_WFETCH)
         |=> (tx_q[1:0] == 2'b00) && (resp_q[0] == $past(vol_q[rd_addr][15:8]));
   endproperty
   a_wfetch: assert property (p_wfetch) else $error("word read answer wrong"); // R11

endmodule

`default_nettype wire
